// *** hdl/scan_trigger_sequencer.sv ***
// trigger-driven relay scan sequencer with register port
`timescale 1ns/100ps
module scan_trigger_sequencer #(
    parameter int DEPTH   = 16,
    parameter int RELAY_W = 8
) (
    // clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    // register port
    input  wire logic [7:0]         i_addr,
    input  wire logic [15:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [15:0]        o_rdata,
    // trigger sources
    input  wire logic [7:0]         i_ttl_trig,
    input  wire logic               i_bus_trig,
    // relay side
    output logic      [RELAY_W-1:0] o_relay,
    output logic                    o_open,
    output logic                    o_close,
    output logic                    o_busy
);
    localparam int AW = $clog2(DEPTH);

    scan_seq_pkg::seq_state_t state;
    scan_seq_pkg::seq_state_t next_state;

    logic [15:0]        count;
    logic [15:0]        delay;
    logic [7:0]         source;
    logic [AW:0]        length;
    logic [15:0]        passes;
    logic [15:0]        dcnt;
    logic [AW-1:0]      idx;
    logic [RELAY_W-1:0] cur;
    logic [11:0]        div;
    logic [7:0]         ttl_s1;
    logic [7:0]         ttl_s2;
    logic               ttl_prev;
    logic [RELAY_W-1:0] mem_rdata;

    // ========================================================
    // register decode
    wire wr_ctrl   = i_wr && (i_addr == scan_seq_pkg::CTRL_OFS);
    wire init_cmd  = wr_ctrl && i_wdata[scan_seq_pkg::INIT_BIT];
    wire abort_cmd = wr_ctrl && i_wdata[scan_seq_pkg::ABORT_BIT];
    wire imm_cmd   = wr_ctrl && i_wdata[scan_seq_pkg::IMM_BIT];
    wire wr_count  = i_wr && (i_addr == scan_seq_pkg::COUNT_OFS)
                     && (i_wdata != 16'h0000);
    wire wr_delay  = i_wr && (i_addr == scan_seq_pkg::DELAY_OFS);
    wire wr_source = i_wr && (i_addr == scan_seq_pkg::SOURCE_OFS);
    wire wr_length = i_wr && (i_addr == scan_seq_pkg::LENGTH_OFS)
                     && (i_wdata <= 16'(DEPTH));
    wire wr_list   = i_wr && (i_addr[7:4] == scan_seq_pkg::LIST_PAGE);

    logic [15:0] rd_mux;
    always_comb begin
        if (i_addr == scan_seq_pkg::COUNT_OFS) begin
            rd_mux = count;
        end else if (i_addr == scan_seq_pkg::DELAY_OFS) begin
            rd_mux = delay;
        end else if (i_addr == scan_seq_pkg::SOURCE_OFS) begin
            rd_mux = {8'h00, source};
        end else if (i_addr == scan_seq_pkg::LENGTH_OFS) begin
            rd_mux = 16'(length);
        end else if (i_addr == scan_seq_pkg::STATUS_OFS) begin
            rd_mux = {8'(cur), 2'b00, state};
        end else if (i_addr == scan_seq_pkg::PASS_OFS) begin
            rd_mux = passes;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            count  <= scan_seq_pkg::COUNT_RST;
            delay  <= scan_seq_pkg::DELAY_RST;
            source <= scan_seq_pkg::SOURCE_RST;
            length <= '0;
        end else begin
            if (wr_count) count <= i_wdata;
            if (wr_delay) delay <= i_wdata;
            if (wr_source) source <= i_wdata[7:0];
            if (wr_length) length <= i_wdata[AW:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_rd ? rd_mux : 16'h0000;
        end
    end

    // ========================================================
    // trigger sources
    wire [1:0] mode = source[scan_seq_pkg::MODE_LSB +: 2];
    wire [2:0] line = source[scan_seq_pkg::LINE_LSB +: 3];
    wire ttl_sel  = ttl_s2[line];
    wire ttl_edge = ttl_sel && !ttl_prev;
    // hold matches no term, so no event can step the scan
    wire trig_event = (mode == scan_seq_pkg::MODE_IMM)
        || (mode == scan_seq_pkg::MODE_BUS && i_bus_trig)
        || (mode == scan_seq_pkg::MODE_TTL && ttl_edge);

    // backplane lines are asynchronous to the system clock
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ttl_s1   <= 8'h00;
            ttl_s2   <= 8'h00;
            ttl_prev <= 1'b0;
        end else begin
            ttl_s1   <= i_ttl_trig;
            ttl_s2   <= ttl_s1;
            ttl_prev <= ttl_sel;
        end
    end

    // ========================================================
    // 100 us tick, restarted when a delay starts so the
    // first tick is whole
    wire tick = (div == scan_seq_pkg::TICK_LAST);
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || state == scan_seq_pkg::S_WAIT || tick) begin
            div <= 12'h000;
        end else begin
            div <= div + 12'h001;
        end
    end

    // ========================================================
    // sequencer
    wire last   = ({1'b0, idx} == length - 1'b1);
    wire finish = last && (passes + 16'h0001 == count);

    always_comb begin
        next_state = state;
        if (abort_cmd) begin
            next_state = scan_seq_pkg::S_IDLE;
        end else begin
            case (state)
            scan_seq_pkg::S_IDLE: begin
                if (init_cmd && length != '0) begin
                    next_state = scan_seq_pkg::S_FETCH;
                end
            end
            scan_seq_pkg::S_WAIT: begin
                if (imm_cmd || (trig_event && delay == 16'h0000)) begin
                    next_state = scan_seq_pkg::S_OPEN;
                end else if (trig_event) begin
                    next_state = scan_seq_pkg::S_DELAY;
                end
            end
            scan_seq_pkg::S_DELAY: begin
                if (imm_cmd || (tick && dcnt == 16'h0001)) begin
                    next_state = scan_seq_pkg::S_OPEN;
                end
            end
            scan_seq_pkg::S_OPEN: begin
                next_state = finish ? scan_seq_pkg::S_IDLE
                                    : scan_seq_pkg::S_FETCH;
            end
            scan_seq_pkg::S_FETCH: next_state = scan_seq_pkg::S_CLOSE;
            scan_seq_pkg::S_CLOSE: next_state = scan_seq_pkg::S_WAIT;
            default: next_state = scan_seq_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state  <= scan_seq_pkg::S_IDLE;
            o_busy <= 1'b0;
        end else begin
            state  <= next_state;
            o_busy <= (next_state != scan_seq_pkg::S_IDLE);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            idx    <= '0;
            passes <= 16'h0000;
            dcnt   <= 16'h0000;
        end else if (state == scan_seq_pkg::S_IDLE && init_cmd) begin
            idx    <= '0;
            passes <= 16'h0000;
        end else if (state == scan_seq_pkg::S_WAIT && trig_event) begin
            dcnt <= delay;
        end else if (state == scan_seq_pkg::S_DELAY && tick) begin
            dcnt <= dcnt - 16'h0001;
        end else if (state == scan_seq_pkg::S_OPEN && !abort_cmd) begin
            idx    <= last ? '0 : idx + 1'b1;
            passes <= last ? passes + 16'h0001 : passes;
        end
    end

    // open goes out from the open state, close two cycles later
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cur     <= '0;
            o_relay <= '0;
            o_open  <= 1'b0;
            o_close <= 1'b0;
        end else begin
            o_open  <= (state == scan_seq_pkg::S_OPEN);
            o_close <= (state == scan_seq_pkg::S_CLOSE);
            if (state == scan_seq_pkg::S_OPEN) begin
                o_relay <= cur;
            end else if (state == scan_seq_pkg::S_CLOSE) begin
                o_relay <= mem_rdata;
                cur     <= mem_rdata;
            end
        end
    end

    scan_list_mem #(
        .WIDTH (RELAY_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_list (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_we      (wr_list),
        .i_waddr   (i_addr[AW-1:0]),
        .i_wdata   (i_wdata[RELAY_W-1:0]),
        .i_raddr   (idx),
        .o_rdata   (mem_rdata)
    );

    // ========================================================
    // assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    reset_values_a: assert property (
        $fell(i_rst) |-> count == 16'h0001 && delay == 16'h0000)
        else $error("count or delay wrong after reset");
    count_nonzero_a: assert property (
        count != 16'h0000)
        else $error("repeat count became zero");
    pass_done_a: assert property (
        state == scan_seq_pkg::S_OPEN && finish && !abort_cmd
        |=> state == scan_seq_pkg::S_IDLE && !o_busy)
        else $error("no return to idle after last pass");
    delay_start_a: assert property (
        state == scan_seq_pkg::S_WAIT && trig_event && !imm_cmd
        && !abort_cmd && delay != 16'h0000
        |=> state == scan_seq_pkg::S_DELAY && dcnt == $past(delay))
        else $error("trigger did not start the delay");
    // split at the fetch so that a legal abort there cannot trip it
    open_close_a: assert property (
        state == scan_seq_pkg::S_OPEN && !finish && !abort_cmd
        |=> o_open && state == scan_seq_pkg::S_FETCH)
        else $error("open not followed by fetch");
    close_follows_a: assert property (
        state == scan_seq_pkg::S_FETCH && !abort_cmd
        |=> state == scan_seq_pkg::S_CLOSE ##1 o_close)
        else $error("fetch not followed by close");
    imm_source_a: assert property (
        state == scan_seq_pkg::S_WAIT && mode == scan_seq_pkg::MODE_IMM
        && delay == 16'h0000 |=> state != scan_seq_pkg::S_WAIT)
        else $error("immediate source did not step");
    hold_source_a: assert property (
        state == scan_seq_pkg::S_WAIT && mode == scan_seq_pkg::MODE_HOLD
        && !imm_cmd && !abort_cmd |=> state == scan_seq_pkg::S_WAIT)
        else $error("hold source let the scan step");
    imm_cmd_a: assert property (
        state == scan_seq_pkg::S_DELAY && imm_cmd && !abort_cmd
        |=> state == scan_seq_pkg::S_OPEN)
        else $error("immediate command did not bypass delay");
    tick_period_a: assert property (
        tick |=> !tick [*8])
        else $error("divider ticks too often");
    abort_idle_a: assert property (
        abort_cmd |=> state == scan_seq_pkg::S_IDLE && !o_busy)
        else $error("abort did not return to idle");

    full_scan_c: cover property (
        state == scan_seq_pkg::S_OPEN && finish && count > 16'h0001);
    delay_path_c: cover property (
        state == scan_seq_pkg::S_DELAY ##1 state == scan_seq_pkg::S_OPEN);
    ttl_step_c: cover property (
        state == scan_seq_pkg::S_WAIT && ttl_edge
        && mode == scan_seq_pkg::MODE_TTL);
    abort_scan_c: cover property (
        abort_cmd && state == scan_seq_pkg::S_DELAY);
endmodule : scan_trigger_sequencer

// *** common/scan_seq_pkg.sv ***
// constants and types shared by the scan trigger sequencer
// ============================================================
// Notes on behaviour
// - repeat count accepts 1..65535 only; reset loads 1
// - repeat count is the number of full passes through the list
// - after the last pass the sequencer returns to idle
// - delay accepts 0..6.5535 s; reset loads 0
// - after a trigger event wait the delay, then open current relay
// - each step opens the current relay, then closes the next
// - immediate source steps continuously without trigger events
// - selected backplane line asserting is the stepping event
// - initiate starts a scan with current count, delay and source
// - hold source disables every trigger source
// - any of backplane lines 0..7 may be the source
// - immediate-trigger command steps at once, skipping wait and delay
// - bus source steps on the host's bus trigger strobe
package scan_seq_pkg;
    // ========================================================
    // register map
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] COUNT_OFS  = 8'h01;
    localparam logic [7:0] DELAY_OFS  = 8'h02;
    localparam logic [7:0] SOURCE_OFS = 8'h03;
    localparam logic [7:0] LENGTH_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h05;
    localparam logic [7:0] PASS_OFS   = 8'h06;
    localparam logic [3:0] LIST_PAGE  = 4'h1;
    localparam int         INIT_BIT   = 0;
    localparam int         ABORT_BIT  = 1;
    localparam int         IMM_BIT    = 2;
    localparam int         MODE_LSB   = 0;
    localparam int         LINE_LSB   = 4;
    // ========================================================
    // reset values and trigger source mode codes
    localparam logic [15:0] COUNT_RST  = 16'h0001;
    localparam logic [15:0] DELAY_RST  = 16'h0000;
    localparam logic [1:0]  MODE_IMM   = 2'h0;
    localparam logic [1:0]  MODE_BUS   = 2'h1;
    localparam logic [1:0]  MODE_HOLD  = 2'h2;
    localparam logic [1:0]  MODE_TTL   = 2'h3;
    localparam logic [7:0]  SOURCE_RST = 8'h00;
    // ========================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS       = 100000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
    // ========================================================
    // sequencer states
    typedef enum logic [5:0] {
        S_IDLE  = 6'h01,
        S_WAIT  = 6'h02,
        S_DELAY = 6'h04,
        S_OPEN  = 6'h08,
        S_FETCH = 6'h10,
        S_CLOSE = 6'h20
    } seq_state_t;
endpackage : scan_seq_pkg

// *** hdl/scan_list_mem.sv ***
// scan list storage with registered read data
`timescale 1ns/100ps
module scan_list_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // write port
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    // read port
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : scan_list_mem

// *** tb/relay_model.sv ***
// behavioural model of the relay modules behind the sequencer
`timescale 1ns/100ps
module relay_model (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // sequencer side
    input  wire logic [7:0] i_relay,
    input  wire logic       i_open,
    input  wire logic       i_close,
    // observation
    output int              o_opens,
    output int              o_closes,
    output logic            o_closed_on,
    output logic [7:0]      o_closed,
    output logic            o_bad
);
    // ========================================================
    // relay state: at most one relay closed at a time
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_opens     <= 0;
            o_closes    <= 0;
            o_closed_on <= 1'b0;
            o_closed    <= 8'h00;
            o_bad       <= 1'b0;
        end else begin
            if (i_open) begin
                o_opens     <= o_opens + 1;
                o_closed_on <= 1'b0;
                if (!o_closed_on || o_closed != i_relay)
                    o_bad <= 1'b1;
            end
            if (i_close) begin
                o_closes    <= o_closes + 1;
                o_closed_on <= 1'b1;
                o_closed    <= i_relay;
                // a second closed relay would short two paths
                if (o_closed_on && !i_open)
                    o_bad <= 1'b1;
            end
        end
    end
endmodule : relay_model

// *** tb/testbench.sv ***
// self-checking bench for the scan trigger sequencer
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin \
    fail_count++; $display("CHECK FAILED t=%0t %s", $time, msg); end end
module testbench;
    logic        i_clk_sys, i_rst, i_wr, i_rd, i_bus_trig;
    logic [7:0]  i_addr, i_ttl_trig, o_relay, closed;
    logic [15:0] i_wdata, o_rdata, rd;
    logic        o_open, o_close, o_busy, closed_on, bad;
    int          opens, closes, fail_count, num_checks, n0, c0, k;

    scan_trigger_sequencer #(.DEPTH(16), .RELAY_W(8)) dut (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ttl_trig(i_ttl_trig), .i_bus_trig(i_bus_trig),
        .o_relay(o_relay), .o_open(o_open), .o_close(o_close),
        .o_busy(o_busy));
    relay_model model (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_relay(o_relay),
        .i_open(o_open), .i_close(o_close), .o_opens(opens),
        .o_closes(closes), .o_closed_on(closed_on), .o_closed(closed),
        .o_bad(bad));

    // ========================================================
    // bus and timing helpers
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 rd = o_rdata;
    endtask : rdr
    task automatic cycles(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cycles
    task automatic pulse_bus();
        @(posedge i_clk_sys);
        i_bus_trig <= 1'b1;
        @(posedge i_clk_sys);
        i_bus_trig <= 1'b0;
    endtask : pulse_bus
    task automatic start(input int len, input logic [15:0] cnt,
                         input logic [15:0] src, input logic [15:0] dly);
        for (int i = 0; i < len; i++)
            wr(8'h10 + 8'(i), 16'hA0 + 16'(i));
        wr(scan_seq_pkg::LENGTH_OFS, 16'(len));
        wr(scan_seq_pkg::COUNT_OFS, cnt);
        wr(scan_seq_pkg::SOURCE_OFS, src);
        wr(scan_seq_pkg::DELAY_OFS, dly);
        n0 = opens;
        c0 = closes;
        wr(scan_seq_pkg::CTRL_OFS, 16'h0001);
    endtask : start
    task automatic wait_idle(input int limit);
        for (int i = 0; i < limit && o_busy !== 1'b0; i++)
            @(posedge i_clk_sys);
        // the last open pulse reaches the relay model one edge later
        repeat (2) @(posedge i_clk_sys);
    endtask : wait_idle

    // ========================================================
    // scenarios
    task automatic t_reset();
        rdr(scan_seq_pkg::COUNT_OFS);
        `CHK(rd, 16'h0001, "count reset")
        rdr(scan_seq_pkg::DELAY_OFS);
        `CHK(rd, 16'h0000, "delay reset")
        wr(scan_seq_pkg::COUNT_OFS, 16'h0000);
        rdr(scan_seq_pkg::COUNT_OFS);
        `CHK(rd, 16'h0001, "count zero taken")
        wr(scan_seq_pkg::COUNT_OFS, 16'hFFFF);
        rdr(scan_seq_pkg::COUNT_OFS);
        `CHK(rd, 16'hFFFF, "count max")
        rdr(8'h07);
        `CHK(rd, 16'h0000, "unmapped read")
        $display("test reset done");
    endtask : t_reset
    task automatic t_imm();
        start(3, 16'h0002, 16'h0000, 16'h0000);
        cycles(2);
        `CHK(o_busy, 1'b1, "scan not started")
        wait_idle(200);
        `CHK(opens - n0, 6, "open count")
        `CHK(closes - c0, 6, "close count")
        `CHK(o_busy, 1'b0, "not idle")
        rdr(scan_seq_pkg::PASS_OFS);
        `CHK(rd, 16'h0002, "passes")
        rdr(scan_seq_pkg::STATUS_OFS);
        `CHK(rd[5:0], 6'h01, "state idle")
        $display("test immediate done");
    endtask : t_imm
    task automatic t_bus();
        start(2, 16'h0001, 16'h0001, 16'h0000);
        cycles(20);
        `CHK(opens - n0, 0, "stepped without trigger")
        pulse_bus();
        cycles(6);
        `CHK(opens - n0, 1, "bus step")
        `CHK(closed, 8'hA1, "next relay")
        pulse_bus();
        wait_idle(20);
        `CHK(opens - n0, 2, "bus final step")
        `CHK(o_busy, 1'b0, "bus not idle")
        $display("test bus done");
    endtask : t_bus
    task automatic t_ttl();
        start(2, 16'h0001, 16'h0073, 16'h0001);
        cycles(10);
        i_ttl_trig <= 8'h40;
        cycles(3);
        i_ttl_trig <= 8'h00;
        cycles(20);
        `CHK(opens - n0, 0, "wrong line stepped")
        i_ttl_trig <= 8'h80;
        k = 0;
        while (o_open !== 1'b1 && k < 3000) begin
            @(posedge i_clk_sys);
            #1 k++;
        end
        `CHK(k >= 2500 && k <= 2510, 1'b1, "delay length")
        cycles(4);
        `CHK(closed, 8'hA1, "line 7 step")
        `CHK(bad, 1'b0, "relay order")
        i_ttl_trig <= 8'h00;
        cycles(10);
        i_ttl_trig <= 8'h80;
        cycles(100);
        `CHK(o_busy, 1'b1, "busy in delay")
        wr(scan_seq_pkg::CTRL_OFS, 16'h0002);
        cycles(3);
        `CHK(o_busy, 1'b0, "abort in delay")
        cycles(2600);
        `CHK(opens - n0, 1, "delay not dropped")
        i_ttl_trig <= 8'h00;
        wr(scan_seq_pkg::CTRL_OFS, 16'h0001);
        cycles(6);
        i_ttl_trig <= 8'h80;
        cycles(10);
        `CHK(o_busy, 1'b1, "rescan not in delay")
        wr(scan_seq_pkg::CTRL_OFS, 16'h0004);
        cycles(4);
        `CHK(opens - n0, 2, "step command in delay")
        wr(scan_seq_pkg::CTRL_OFS, 16'h0002);
        cycles(3);
        `CHK(o_busy, 1'b0, "abort after step")
        i_ttl_trig <= 8'h00;
        $display("test ttl done");
    endtask : t_ttl
    task automatic t_hold();
        start(2, 16'h0001, 16'h0002, 16'h0000);
        cycles(10);
        i_ttl_trig <= 8'hFF;
        pulse_bus();
        cycles(20);
        `CHK(opens - n0, 0, "hold stepped")
        i_ttl_trig <= 8'h00;
        wr(scan_seq_pkg::CTRL_OFS, 16'h0004);
        cycles(8);
        `CHK(opens - n0, 1, "step command open")
        `CHK(closes - c0, 2, "step command close")
        wr(scan_seq_pkg::CTRL_OFS, 16'h0002);
        cycles(3);
        `CHK(o_busy, 1'b0, "abort")
        $display("test hold done");
    endtask : t_hold

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // ========================================================
    // clock, watchdog and main sequence
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    // the ttl test dominates at about 5300 cycles
    initial begin
        #(40 * 40000);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        fail_count = 0;
        num_checks = 0;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 16'h0000;
        i_ttl_trig = 8'h00;
        i_bus_trig = 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_reset();
        t_imm();
        t_bus();
        t_ttl();
        t_hold();
        tally_and_finish();
    end
endmodule : testbench
